// File: hw/irq_seq_pkg.sv
package irq_seq_pkg;
  // ==========================================================
  // Sources and vectors
  // ==========================================================
  localparam int          NUM_SRC        = 16;
  localparam logic [3:0]  SRC_SWTRAP     = 4'h1;
  localparam logic [3:0]  SRC_WDT        = 4'h2;
  localparam logic [3:0]  SRC_EXT0       = 4'h3;
  localparam logic [3:0]  SRC_EXT1       = 4'h5;
  localparam logic [3:0]  SRC_EXT2       = 4'h7;
  localparam logic [3:0]  SRC_EXT3       = 4'hB;
  localparam logic [3:0]  SRC_EXT4       = 4'hC;
  localparam logic [3:0]  SRC_EXT5       = 4'hF;
  localparam logic [15:0] VEC_BASE       = 16'hFFFE;
  localparam logic [15:0] MASKABLE_SRCS  = 16'hFFF8;
  localparam logic [7:0]  TRAP_OPCODE    = 8'hFF;
  localparam logic [7:0]  EMPTY_FETCH    = 8'hFF;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int          ACCEPT_CYCLES  = 8;
  localparam int          RET_SP_STEPS   = 3;
  localparam int          FLT_SHORT_FC   = 7;
  localparam int          FLT_E1_FAST_FC = 15;
  localparam int          FLT_E1_SLOW_FC = 63;
  // ==========================================================
  // Register map (APB byte addresses)
  // ==========================================================
  localparam logic [7:0]  ADDR_ENABLE    = 8'h00;
  localparam logic [7:0]  ADDR_PENDING   = 8'h04;
  localparam logic [7:0]  ADDR_EXTCTRL   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
  localparam int          EC_EXT0_EN     = 0;
  localparam int          EC_EXT1_NS     = 1;
  localparam int          EC_EDGE_LO     = 2;
  localparam logic [7:0]  EXTCTRL_RST    = 8'h00;

  typedef struct packed {
    logic       instr_last;
    logic       is_mret;
    logic       is_nret;
    logic       is_trap;
    logic [7:0] status_word;
    logic [15:0] pc;
  } cpu_req_t;

  typedef struct packed {
    logic        push_valid;
    logic [15:0] push_pc;
    logic [7:0]  push_psw;
    logic        load_pc;
    logic [15:0] vec_addr;
    logic [1:0]  sp_inc;
  } cpu_ack_t;
endpackage

// File: hw/irq_sequencer.sv
`timescale 1ns/1ps
// Summary of operation
// R1 - Pending request stays latched until accepted, reset, or cleared by software.
// R2 - Acceptance sequence lasts eight machine cycles after the current instruction.
// R3 - Acceptance clears master enable; non-maskable acceptance blocks all interrupts.
// R4 - Acceptance clears the accepted source's pending latch.
// R5 - Acceptance pushes return PC and status word, nothing else.
// R6 - Vector slot of accepted source is loaded into the PC.
// R7 - Master enable low blocks every maskable request.
// R8 - External 0 is gated only by master enable and its pin enable.
// R9 - Either return restores the previous bank selector.
// R10 - Maskable return restores PC and status, steps SP three times, sets enable.
// R11 - Non-maskable return sets enable only if it was set at acceptance.
// R12 - Requests are sampled in the final cycle of each instruction.
// R13 - External 0 pin enable low stops falling edges setting its latch.
// R14 - Shared external 0 pin comes up as plain port input after reset.
// R15 - Inputs 1 to 4 edge selectable; inputs 0 and 5 falling only.
// R16 - External 1 filter rejects under 15 or 63 clocks by noise select.
// R17 - Inputs 2 to 4 and timer pins reject pulses under 7 clocks.
// R18 - Noise filtering bypassed in low-speed mode.
// R19 - Latch sets within 49/193 clocks for input 1, 25 for 2 to 4.
// R20 - Outside driver holds input 0 and 5 levels over one machine cycle.
// R21 - Software trap is highest priority; a no-op during non-maskable service.
// R22 - Fetches from unpopulated memory return the trap opcode.
// R23 - Highest fixed priority wins among simultaneous requests.
// R24 - Software may clear pending latches but never set them.
// R25 - Non-maskable interrupts never nest; second waits for return.
// R26 - Inputs synchronised, filtered, then turned into one-cycle set pulses; inputs 0 and 5 bypass the filter here.
module irq_sequencer
  import irq_seq_pkg::*;
#(
  parameter int MC_CLKS = 4
) (
  input  wire logic        ref_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire cpu_req_t    cpu_req_in,
  output cpu_ack_t         cpu_ack_out,
  output logic             cpu_busy_out,
  input  wire logic [3:0]  bank_in,
  output logic [3:0]       bank_out,
  output logic             bank_load_out,
  input  wire logic        low_speed_in,
  input  wire logic [15:0] periph_irq_in,
  input  wire logic [5:0]  ext_pin_in,
  input  wire logic [2:0]  timer_pin_in,
  output logic [2:0]       timer_clean_out,
  input  wire logic        fetch_unpop_in,
  input  wire logic [7:0]  fetch_data_in,
  output logic [7:0]       fetch_data_out,
  output logic             port1_bit0_is_irq_out
);
  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [3:0] pick_src(input logic [15:0] req);
    pick_src = 4'h0;
    for (int i = NUM_SRC - 1; i >= 1; i--) begin
      if (req[i]) begin
        pick_src = 4'(i);  // R23
      end
    end
  endfunction

  function automatic logic [7:0] flt_step(input logic [7:0] cnt, input logic same,
                                          input logic [7:0] lim);
    if (same) begin
      flt_step = 8'h00;
    end else if (cnt < lim) begin
      flt_step = cnt + 8'h01;
    end else begin
      flt_step = cnt;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers and noise filters
  // ==========================================================
  localparam int NPIN = 9;
  logic [NPIN-1:0] sync1, sync2, clean, next_clean;
  logic [NPIN-1:0] pins_raw;
  logic [7:0]      flt_cnt [NPIN];
  logic [7:0]      next_flt_cnt [NPIN];
  logic [7:0]      ext_ctrl, next_ext_ctrl;
  logic [15:0]     enable_flags, next_enable_flags;
  logic            master_irq_enable, next_master_irq_enable;
  logic [15:0]     pending_latch, next_pending_latch;
  logic [5:0]      edge_set;
  logic [3:0]      edge_hi;

  assign pins_raw = {timer_pin_in, ext_pin_in};

  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      logic [7:0] lim;
      lim = 8'(FLT_SHORT_FC);  // R17
      if (i == 1) begin
        lim = ext_ctrl[EC_EXT1_NS] ? 8'(FLT_E1_FAST_FC) : 8'(FLT_E1_SLOW_FC);  // R16
      end
      next_flt_cnt[i] = flt_step(flt_cnt[i], sync2[i] == clean[i], lim);
      next_clean[i]   = clean[i];
      if (i == 0 || i == 5 || low_speed_in) begin
        next_clean[i] = sync2[i];  // R18
      end else if (next_flt_cnt[i] >= lim) begin
        next_clean[i] = sync2[i];  // R19
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1 <= '1;
      sync2 <= '1;
      clean <= '1;
      for (int i = 0; i < NPIN; i++) begin
        flt_cnt[i] <= 8'h00;
      end
    end else begin
      sync1 <= pins_raw;  // R26
      sync2 <= sync1;
      clean <= next_clean;
      flt_cnt <= next_flt_cnt;
    end
  end

  assign timer_clean_out = clean[8:6];
  assign edge_hi         = ext_ctrl[EC_EDGE_LO+3:EC_EDGE_LO];

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      logic fall, rise;
      fall = clean[i] && !next_clean[i];
      rise = !clean[i] && next_clean[i];
      edge_set[i] = fall;  // R15
      if (i >= 1 && i <= 4) begin
        edge_set[i] = edge_hi[i-1] ? rise : fall;  // R15
      end
    end
    edge_set[0] = edge_set[0] && ext_ctrl[EC_EXT0_EN];  // R13
  end

  assign port1_bit0_is_irq_out = ext_ctrl[EC_EXT0_EN];  // R14

  // ==========================================================
  // Acceptance and return sequencer
  // ==========================================================
  typedef enum logic [1:0] {ST_RUN, ST_ACCEPT, ST_VECTOR} seq_t;
  seq_t        state, next_state;
  logic [7:0]  cyc, next_cyc;
  logic [3:0]  cur_src, next_cur_src;
  logic        nmi_busy, next_nmi_busy;
  logic        nmi_saved_ime, next_nmi_saved_ime;
  logic [3:0]  bank_stack [16];
  logic [3:0]  next_bank_top;
  logic [3:0]  depth, next_depth;
  logic [15:0] hw_set, req_vec;
  logic [3:0]  win;
  logic        trap_go;
  cpu_ack_t    ack, next_ack;
  logic        bank_ld, next_bank_ld;
  logic [3:0]  bank_val, next_bank_val;
  logic        apb_wr_pend;
  logic [15:0] sw_clear;

  assign trap_go = cpu_req_in.instr_last && cpu_req_in.is_trap && !nmi_busy;  // R21

  always_comb begin
    hw_set = periph_irq_in & ~16'h000B;
    hw_set[SRC_EXT0] = edge_set[0];
    hw_set[SRC_EXT1] = edge_set[1];
    hw_set[SRC_EXT2] = edge_set[2];
    hw_set[SRC_EXT3] = edge_set[3];
    hw_set[SRC_EXT4] = edge_set[4];
    hw_set[SRC_EXT5] = edge_set[5];
    hw_set[SRC_WDT]  = periph_irq_in[SRC_WDT];
    req_vec = pending_latch & ((master_irq_enable ? 16'hFFFF : 16'h0000)  // R7
              & (enable_flags | {12'h000, ext_ctrl[EC_EXT0_EN], 3'b000}) & MASKABLE_SRCS);  // R8
    if (!nmi_busy) begin
      req_vec[SRC_WDT] = pending_latch[SRC_WDT];  // R25
    end
    req_vec[SRC_SWTRAP] = trap_go;
    win = pick_src(req_vec);  // R23
  end

  always_comb begin
    next_state             = state;
    next_cyc               = cyc;
    next_cur_src           = cur_src;
    next_nmi_busy          = nmi_busy;
    next_nmi_saved_ime     = nmi_saved_ime;
    next_master_irq_enable = master_irq_enable;
    next_depth             = depth;
    next_bank_top          = bank_in;
    next_ack               = '0;
    next_bank_ld           = 1'b0;
    next_bank_val          = bank_val;
    next_pending_latch     = (pending_latch & ~sw_clear) | hw_set;  // R1 R24
    if (apb_wr_pend && paddr_in == ADDR_ENABLE) begin
      next_master_irq_enable = pwdata_in[0];
      if (nmi_busy && !pwdata_in[0]) begin
        next_nmi_saved_ime = 1'b0;  // R11
      end
    end
    case (state)
      ST_RUN: begin
        if (cpu_req_in.instr_last && cpu_req_in.is_mret) begin
          next_ack.load_pc       = 1'b0;
          next_ack.sp_inc        = 2'(RET_SP_STEPS);  // R10
          next_master_irq_enable = 1'b1;  // R10
          next_bank_ld           = 1'b1;  // R9
          next_bank_val          = bank_stack[depth - 4'h1];
          next_depth             = depth - 4'h1;
        end else if (cpu_req_in.instr_last && cpu_req_in.is_nret) begin
          next_ack.sp_inc        = 2'(RET_SP_STEPS);
          next_master_irq_enable = next_nmi_saved_ime;  // R11
          next_nmi_busy          = 1'b0;  // R25
          next_bank_ld           = 1'b1;  // R9
          next_bank_val          = bank_stack[depth - 4'h1];
          next_depth             = depth - 4'h1;
        end else if (cpu_req_in.instr_last && win != 4'h0) begin  // R12
          next_state             = ST_ACCEPT;
          next_cyc               = 8'h00;
          next_cur_src           = win;
          next_master_irq_enable = 1'b0;  // R3
          if (!MASKABLE_SRCS[win]) begin
            next_nmi_busy      = 1'b1;  // R3
            next_nmi_saved_ime = master_irq_enable;
          end
          next_pending_latch[win] = 1'b0;  // R4
          next_ack.push_valid     = 1'b1;  // R5
          next_ack.push_pc        = cpu_req_in.pc;
          next_ack.push_psw       = cpu_req_in.status_word;
          next_depth              = depth + 4'h1;
        end
      end
      ST_ACCEPT: begin
        next_cyc = cyc + 8'h01;
        if (next_cyc == 8'(ACCEPT_CYCLES * MC_CLKS - 1)) begin  // R2
          next_state = ST_VECTOR;
        end
      end
      ST_VECTOR: begin
        next_ack.load_pc  = 1'b1;  // R6
        next_ack.vec_addr = VEC_BASE - {11'h000, cur_src, 1'b0};
        next_state        = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state             <= ST_RUN;
      cyc               <= 8'h00;
      cur_src           <= 4'h0;
      nmi_busy          <= 1'b0;
      nmi_saved_ime     <= 1'b0;
      master_irq_enable <= 1'b0;
      pending_latch     <= 16'h0000;
      depth             <= 4'h0;
      ack               <= '0;
      bank_ld           <= 1'b0;
      bank_val          <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        bank_stack[i] <= 4'h0;
      end
    end else begin
      state             <= next_state;
      cyc               <= next_cyc;
      cur_src           <= next_cur_src;
      nmi_busy          <= next_nmi_busy;
      nmi_saved_ime     <= next_nmi_saved_ime;
      master_irq_enable <= next_master_irq_enable;
      pending_latch     <= next_pending_latch;
      depth             <= next_depth;
      ack               <= next_ack;
      bank_ld           <= next_bank_ld;
      bank_val          <= next_bank_val;
      if (next_ack.push_valid) begin
        bank_stack[depth] <= next_bank_top;  // R9
      end
    end
  end

  assign cpu_ack_out   = ack;
  assign cpu_busy_out  = (state != ST_RUN);
  assign bank_out      = bank_val;
  assign bank_load_out = bank_ld;

  // ==========================================================
  // Empty fetch substitution
  // ==========================================================
  logic [7:0] fetch_q, next_fetch_q;
  assign next_fetch_q = fetch_unpop_in ? EMPTY_FETCH : fetch_data_in;  // R22
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fetch_q <= TRAP_OPCODE;
    end else begin
      fetch_q <= next_fetch_q;
    end
  end
  assign fetch_data_out = fetch_q;

  // ==========================================================
  // APB slave
  // ==========================================================
  logic [31:0] rdata, next_rdata;
  logic        addr_ok;
  assign apb_wr_pend = psel_in && penable_in && pwrite_in;
  assign addr_ok     = (paddr_in == ADDR_ENABLE) || (paddr_in == ADDR_PENDING)
                       || (paddr_in == ADDR_EXTCTRL) || (paddr_in == ADDR_STATUS);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;
  assign sw_clear    = (apb_wr_pend && paddr_in == ADDR_PENDING) ? ~pwdata_in[15:0]
                       : 16'h0000;  // R24

  always_comb begin
    next_enable_flags = enable_flags;
    next_ext_ctrl     = ext_ctrl;
    next_rdata        = 32'h0000_0000;
    if (apb_wr_pend && paddr_in == ADDR_ENABLE) begin
      next_enable_flags = pwdata_in[15:0] & MASKABLE_SRCS & ~16'h0008;  // R8
    end
    if (apb_wr_pend && paddr_in == ADDR_EXTCTRL) begin
      next_ext_ctrl = pwdata_in[7:0];
    end
    if (psel_in && !penable_in && !pwrite_in) begin
      case (paddr_in)
        ADDR_ENABLE:  next_rdata = {16'h0000, enable_flags[15:1], master_irq_enable};
        ADDR_PENDING: next_rdata = {16'h0000, pending_latch};
        ADDR_EXTCTRL: next_rdata = {24'h00_0000, ext_ctrl};
        ADDR_STATUS:  next_rdata = {22'h00_0000, depth, nmi_busy, cpu_busy_out, cur_src};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      enable_flags <= 16'h0000;
      ext_ctrl     <= EXTCTRL_RST;  // R14
      rdata        <= 32'h0000_0000;
    end else begin
      enable_flags <= next_enable_flags;
      ext_ctrl     <= next_ext_ctrl;
      rdata        <= next_rdata;
    end
  end
  assign prdata_out = rdata;

  // ==========================================================
  // Checks
  // ==========================================================
  accept_len_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(cpu_busy_out) |-> ##31 cpu_busy_out ##1 !cpu_busy_out)  // R2
    else $error("acceptance length wrong");
  accept_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $fell(cpu_busy_out) |-> $past(cpu_busy_out, 32))  // R2
    else $error("acceptance cut short");
  accept_ime_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(cpu_busy_out) |-> !master_irq_enable)  // R3
    else $error("enable not cleared on accept");
  accept_clr_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(cpu_busy_out) && cur_src > 4'h2 |-> !pending_latch[cur_src] || $past(hw_set[cur_src]))  // R4
    else $error("latch not cleared");
  push_ctx_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(cpu_busy_out) |-> cpu_ack_out.push_valid)  // R5
    else $error("no push on accept");
  vector_load_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $fell(cpu_busy_out) |-> cpu_ack_out.load_pc
      && cpu_ack_out.vec_addr == VEC_BASE - {11'h000, cur_src, 1'b0})  // R6
    else $error("bad vector");
  mask_gate_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(cpu_busy_out) && cur_src > 4'h2 |-> $past(master_irq_enable))  // R7
    else $error("maskable taken while disabled");
  mret_ime_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cpu_req_in.instr_last && cpu_req_in.is_mret && !cpu_busy_out |=> master_irq_enable
      && cpu_ack_out.sp_inc == 2'd3)  // R10
    else $error("maskable return wrong");
  sw_noset_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(pending_latch[SRC_EXT0]) |-> $past(edge_set[0]))  // R24
    else $error("latch set without event");
  nmi_nest_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    $rose(cpu_busy_out) && cur_src < 4'h3 |-> !$past(nmi_busy))  // R25
    else $error("non-maskable nested");
endmodule

// File: tb/cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model
  import irq_seq_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       busy_in,
  output cpu_req_t        req_out,
  output logic      [5:0] pin_out
);
  // ====================
  // Instruction ends and pins
  // ====================
  initial begin
    req_out = '0;
    pin_out = 6'h3F;
  end

  // Qualifiers turn to garbage once the final cycle is over
  task automatic end_instr(input logic [2:0] kind, input logic [23:0] ctx);
    @(posedge clk_in);
    while (busy_in === 1'b1) @(posedge clk_in);
    req_out <= {1'b1, kind, ctx};
    @(posedge clk_in);
    req_out <= {1'b0, ~kind, ~ctx};
  endtask

  // Every level is held longer than one machine cycle
  task automatic hold(input int idx, input logic lvl, input int n);
    @(posedge clk_in);
    pin_out[idx] <= lvl;
    repeat (n) @(posedge clk_in);
  endtask
endmodule

// File: tb/mcu_interrupt_sequencer_bench.sv
`timescale 1ns/1ps
module mcu_interrupt_sequencer_bench
  import irq_seq_pkg::*;
;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  cpu_req_t    req;
  cpu_ack_t    ack;
  logic        busy, bank_load, lows, unpop, p1irq, err;
  logic [3:0]  bank, bank_out, bank_exp;
  logic [15:0] periph;
  logic [5:0]  pins;
  logic [2:0]  tclean, tpins;
  logic [7:0]  fdat, fout;
  integer      seed = 94;
  int          failures = 0;
  int          n_compared = 0;
  int          cyc = 0;
  localparam int MC_CLKS = 4;

  irq_sequencer #(.MC_CLKS(MC_CLKS)) u_dut (
    .ref_clk_in            (clk),
    .nrst_in               (nrst),
    .psel_in               (psel),
    .penable_in            (penable),
    .pwrite_in             (pwrite),
    .paddr_in              (paddr),
    .pwdata_in             (pwdata),
    .prdata_out            (prdata),
    .pready_out            (pready),
    .pslverr_out           (pslverr),
    .cpu_req_in            (req),
    .cpu_ack_out           (ack),
    .cpu_busy_out          (busy),
    .bank_in               (bank),
    .bank_out              (bank_out),
    .bank_load_out         (bank_load),
    .low_speed_in          (lows),
    .periph_irq_in         (periph),
    .ext_pin_in            (pins),
    .timer_pin_in          (tpins),
    .timer_clean_out       (tclean),
    .fetch_unpop_in        (unpop),
    .fetch_data_in         (fdat),
    .fetch_data_out        (fout),
    .port1_bit0_is_irq_out (p1irq)
  );

  cpu_core_model u_cpu (
    .clk_in  (clk),
    .busy_in (busy),
    .req_out (req),
    .pin_out (pins)
  );

  // ====================
  // Clock and watchdog on the run
  // ====================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ====================
  // Helpers
  // ====================
  function automatic logic [15:0] vec(input logic [3:0] s);
    return VEC_BASE - {11'h000, s, 1'b0};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  task automatic pulse_src(input int i);
    @(posedge clk);
    periph <= 16'h0001 << i;
    @(posedge clk);
    periph <= 16'h0000;
  endtask

  // Ends an instruction; v is the expected vector, zero when none is due
  task automatic run(input logic [2:0] k, input logic [15:0] v);
    int nb;
    logic pv, lp;
    logic [23:0] ctx;
    nb = 0;
    pv = 1'b0;
    lp = 1'b0;
    ctx = 24'($random(seed));
    @(posedge clk);
    bank <= 4'($random(seed));
    u_cpu.end_instr(k, ctx);
    repeat (40) begin
      #1;
      if (ack.push_valid === 1'b1) begin
        pv = 1'b1;
        chk({8'h00, ack.push_psw, ack.push_pc}, {8'h00, ctx});
      end
      if (busy === 1'b1) nb++;
      if (ack.load_pc === 1'b1 && !lp) begin
        lp = 1'b1;
        chk({16'h0000, ack.vec_addr}, {16'h0000, v});
        chk(32'(nb), 32'(ACCEPT_CYCLES * MC_CLKS));
      end
      @(posedge clk);
    end
    chk(32'(pv), 32'(v != 16'h0000));
    if (v != 16'h0000) begin
      bank_exp = bank;
      @(posedge clk);
      bank <= ~bank_exp;
    end
  endtask

  task automatic ret(input logic [2:0] k);
    logic seen;
    seen = 1'b0;
    u_cpu.end_instr(k, 24'h00_0000);
    repeat (4) begin
      #1;
      if (bank_load === 1'b1) begin
        seen = 1'b1;
        chk(32'(bank_out), 32'(bank_exp));
        chk(32'(ack.sp_inc), 32'(RET_SP_STEPS));
      end
      @(posedge clk);
    end
    chk(32'(seen), 32'h0000_0001);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ====================
  // Main sequence
  // ====================
  initial begin
    nrst = 1'b0;
    {psel, penable, pwrite, lows, unpop} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    bank = 4'h0;
    periph = 16'h0000;
    fdat = 8'h00;
    tpins = 3'b111;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_ENABLE, 32'h0000_0000);
    rd(ADDR_PENDING, 32'h0000_0000);
    rd(ADDR_EXTCTRL, 32'(EXTCTRL_RST));
    chk(32'(p1irq), 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    repeat (8) begin
      @(posedge clk);
      fdat <= 8'($random(seed));
      unpop <= 1'($random(seed));
      @(posedge clk);
      #1;
      chk(32'(fout), 32'(unpop ? EMPTY_FETCH : fdat));
    end
    pulse_src(4);
    rd(ADDR_PENDING, 32'h0000_0010);
    wr(ADDR_PENDING, 32'hFFFF_FFFF);
    rd(ADDR_PENDING, 32'h0000_0010);
    wr(ADDR_ENABLE, 32'h0000_0050);
    pulse_src(6);
    run(3'b000, 16'h0000);
    wr(ADDR_ENABLE, 32'h0000_0051);
    run(3'b000, vec(4'h4));
    rd(ADDR_PENDING, 32'h0000_0040);
    rd(ADDR_ENABLE, 32'h0000_0050);
    ret(3'b100);
    rd(ADDR_ENABLE, 32'h0000_0051);
    run(3'b000, vec(4'h6));
    ret(3'b100);
    wr(ADDR_ENABLE, 32'h0000_0000);
    run(3'b001, vec(SRC_SWTRAP));
    pulse_src(2);
    run(3'b000, 16'h0000);
    run(3'b001, 16'h0000);
    ret(3'b010);
    rd(ADDR_ENABLE, 32'h0000_0000);
    run(3'b000, vec(SRC_WDT));
    ret(3'b010);
    wr(ADDR_ENABLE, 32'h0000_0001);
    run(3'b001, vec(SRC_SWTRAP));
    ret(3'b010);
    rd(ADDR_ENABLE, 32'h0000_0001);
    run(3'b001, vec(SRC_SWTRAP));
    wr(ADDR_ENABLE, 32'h0000_0000);
    ret(3'b010);
    rd(ADDR_ENABLE, 32'h0000_0000);
    wr(ADDR_ENABLE, 32'h0000_0001);
    u_cpu.hold(0, 1'b0, 10);
    u_cpu.hold(0, 1'b1, 10);
    rd(ADDR_PENDING, 32'h0000_0000);
    wr(ADDR_EXTCTRL, 32'h0000_0001);
    #1;
    chk(32'(p1irq), 32'h0000_0001);
    u_cpu.hold(0, 1'b0, 10);
    u_cpu.hold(0, 1'b1, 10);
    rd(ADDR_PENDING, 32'h0000_0008);
    run(3'b000, vec(SRC_EXT0));
    ret(3'b100);
    wr(ADDR_EXTCTRL, 32'h0000_000B);
    u_cpu.hold(2, 1'b0, 30);
    rd(ADDR_PENDING, 32'h0000_0000);
    u_cpu.hold(2, 1'b1, 22);
    rd(ADDR_PENDING, 32'h0000_0080);
    wr(ADDR_PENDING, 32'h0000_0000);
    u_cpu.hold(2, 1'b0, 5);
    u_cpu.hold(2, 1'b1, 30);
    rd(ADDR_PENDING, 32'h0000_0000);
    @(posedge clk);
    lows <= 1'b1;
    u_cpu.hold(2, 1'b0, 5);
    u_cpu.hold(2, 1'b1, 30);
    rd(ADDR_PENDING, 32'h0000_0080);
    @(posedge clk);
    lows <= 1'b0;
    wr(ADDR_PENDING, 32'h0000_0000);
    u_cpu.hold(1, 1'b0, 12);
    u_cpu.hold(1, 1'b1, 30);
    rd(ADDR_PENDING, 32'h0000_0000);
    u_cpu.hold(1, 1'b0, 46);
    rd(ADDR_PENDING, 32'h0000_0020);
    u_cpu.hold(1, 1'b1, 30);
    wr(ADDR_EXTCTRL, 32'h0000_0009);
    wr(ADDR_PENDING, 32'h0000_0000);
    u_cpu.hold(1, 1'b0, 50);
    u_cpu.hold(1, 1'b1, 30);
    rd(ADDR_PENDING, 32'h0000_0000);
    @(posedge clk);
    tpins <= 3'b110;
    repeat (6) @(posedge clk);
    tpins <= 3'b111;
    #1;
    chk(32'(tclean), 32'h0000_0007);
    @(posedge clk);
    tpins <= 3'b110;
    repeat (24) @(posedge clk);
    #1;
    chk(32'(tclean), 32'h0000_0006);
    tally_and_finish();
  end
endmodule
